// ---- include/stall_pkg.sv ----
// Constants and types shared by the stall prevention logic
package stall_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned RUN_DWELL_MS = 100;
  localparam int unsigned RUN_DWELL_CYCLES = CLK_HZ / 1000 * RUN_DWELL_MS;
  localparam logic [7:0] PCT_MIN = 8'h32;
  localparam logic [7:0] PCT_MAX = 8'hc8;
  localparam logic [7:0] PCT_RESET = 8'h96;
  localparam logic [4:0] GAIN_MAX = 5'h19;
  localparam logic [4:0] GAIN_RESET = 5'h0a;
  localparam logic [12:0] BUS200_MIN = 13'h0dac;
  localparam logic [12:0] BUS200_MAX = 13'h0f3c;
  localparam logic [12:0] BUS200_RESET = 13'h0ed8;
  localparam logic [12:0] BUS400_MIN = 13'h1b58;
  localparam logic [12:0] BUS400_MAX = 13'h1e78;
  localparam logic [12:0] BUS400_RESET = 13'h1db0;
  localparam logic [12:0] BUS200_OV_TRIP = 13'h1004;
  localparam logic [12:0] BUS400_OV_TRIP = 13'h2008;
  localparam logic [3:0] ADDR_SEL = 4'h0;
  localparam logic [3:0] ADDR_ACC_LIM = 4'h1;
  localparam logic [3:0] ADDR_DEC_LIM = 4'h2;
  localparam logic [3:0] ADDR_RUN_LIM = 4'h3;
  localparam logic [3:0] ADDR_OV_LEVEL = 4'h4;
  localparam logic [3:0] ADDR_GAIN = 4'h5;
  localparam logic [3:0] ADDR_ACC_ONE = 4'h6;
  localparam logic [3:0] ADDR_DEC_ONE = 4'h7;
  localparam logic [3:0] ADDR_ACC_TWO = 4'h8;
  localparam logic [3:0] ADDR_DEC_TWO = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'ha;
  localparam logic [3:0] ADDR_FAULT_CLR = 4'hb;
  localparam logic [15:0] STEP_RESET = 16'h0010;
  typedef enum logic [1:0] {DEC_OFF, DEC_ALL, DEC_CHANGE_ONLY} decel_sel_e;
  typedef enum {RAMP_IDLE, RAMP_ACCEL, RAMP_DECEL, RAMP_STEADY, RAMP_STALLED} ramp_state_e;
endpackage : stall_pkg

// ---- include/limit_if.sv ----
// Limit request and result bundle between ramp core and limit checker
`timescale 1ns/1ps
interface limit_if;
  logic [15:0] current;
  logic [7:0] acc_pct;
  logic [7:0] dec_pct;
  logic [7:0] run_pct;
  logic over_acc;
  logic over_dec;
  logic over_run;
  logic on_acc;
  logic on_dec;
  logic on_run;
  modport core (output current, acc_pct, dec_pct, run_pct,
                input over_acc, over_dec, over_run, on_acc, on_dec, on_run);
  modport check (input current, acc_pct, dec_pct, run_pct,
                 output over_acc, over_dec, over_run, on_acc, on_dec, on_run);
endinterface : limit_if

// ---- logic/limit_check.sv ----
// Registered current comparison against each percent limit
`timescale 1ns/1ps
module limit_check #(
  parameter int unsigned RATED = 1000
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  limit_if.check lim
);
  function automatic logic [23:0] scaled(input logic [7:0] pct);
    scaled = 24'(pct) * 24'(RATED);
  endfunction : scaled
  logic [23:0] cur100;
  assign cur100 = 24'(lim.current) * 24'h000064;
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lim.over_acc <= 1'b0;
      lim.over_dec <= 1'b0;
      lim.over_run <= 1'b0;
    end
    else
    begin
      lim.over_acc <= cur100 > scaled(lim.acc_pct);
      lim.over_dec <= cur100 > scaled(lim.dec_pct);
      lim.over_run <= cur100 > scaled(lim.run_pct);
    end
  end
  assign lim.on_acc = lim.acc_pct != stall_pkg::PCT_MAX;
  assign lim.on_dec = lim.dec_pct != stall_pkg::PCT_MAX;
  assign lim.on_run = lim.run_pct != stall_pkg::PCT_MAX;
endmodule : limit_check

// ---- logic/stall_prevention_controller.sv ----
// Frequency ramp with stall and overvoltage prevention, Avalon-MM registers
`timescale 1ns/1ps
module stall_prevention_controller #(
  parameter int unsigned RATED = 1000,
  parameter int unsigned DWELL_CYCLES = stall_pkg::RUN_DWELL_CYCLES,
  parameter bit CLASS_400 = 1'b0
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic run_i,
  input wire logic [15:0] target_freq_i,
  input wire logic [15:0] current_i,
  input wire logic [12:0] bus_volt_i,
  input wire logic update_i,
  output logic [15:0] freq_o,
  output logic overvoltage_fault_o,
  output logic overload_fault_o,
  output logic overcurrent_fault_o,
  output logic stalled_o
);
  localparam logic [12:0] LVL_MIN = CLASS_400 ? stall_pkg::BUS400_MIN : stall_pkg::BUS200_MIN;
  localparam logic [12:0] LVL_MAX = CLASS_400 ? stall_pkg::BUS400_MAX : stall_pkg::BUS200_MAX;
  localparam logic [12:0] LVL_RST = CLASS_400 ? stall_pkg::BUS400_RESET : stall_pkg::BUS200_RESET;
  localparam logic [12:0] OV_TRIP = CLASS_400 ? stall_pkg::BUS400_OV_TRIP :
                                    stall_pkg::BUS200_OV_TRIP;
  localparam logic [31:0] DWELL = 32'(DWELL_CYCLES);

  logic accel_stall_prevent_select;
  stall_pkg::decel_sel_e decel_stall_prevent_select;
  logic running_stall_prevent_select;
  logic running_overvolt_prevent_select;
  logic [7:0] accel_current_limit_level;
  logic [7:0] decel_current_limit_level;
  logic [7:0] running_current_limit_level;
  logic [12:0] running_overvolt_prevent_level;
  logic [4:0] decel_overvolt_restraint_gain;
  logic [15:0] accel_time_one;
  logic [15:0] decel_time_one;
  logic [15:0] accel_time_two;
  logic [15:0] decel_time_two;
  logic use_two;
  logic bus_wait;
  stall_pkg::ramp_state_e state;
  logic [31:0] dwell_cnt;
  logic run_limiting;
  logic [15:0] set_freq;

  limit_if lim();
  assign lim.current = current_i;
  assign lim.acc_pct = accel_current_limit_level;
  assign lim.dec_pct = decel_current_limit_level;
  assign lim.run_pct = running_current_limit_level;

  limit_check #(.RATED(RATED)) u_check (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .lim(lim)
  );

  function automatic logic [7:0] clip_pct(input logic [31:0] d);
    if (d[7:0] < stall_pkg::PCT_MIN || d[31:8] != 24'h0)
      clip_pct = (d[31:8] != 24'h0) ? stall_pkg::PCT_MAX : stall_pkg::PCT_MIN;
    else if (d[7:0] > stall_pkg::PCT_MAX)
      clip_pct = stall_pkg::PCT_MAX;
    else
      clip_pct = d[7:0];
  endfunction : clip_pct

  logic wr;
  logic rd;
  assign wr = write_i && !bus_wait;
  // Read data load in the wait state so they stand at the accepting edge
  assign rd = read_i && bus_wait;

  // One wait state per access so read data can come from a flop
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      bus_wait <= 1'b1;
    else if (read_i || write_i)
      bus_wait <= !bus_wait;
    else
      bus_wait <= 1'b1;
  end
  assign waitrequest_o = bus_wait;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      accel_stall_prevent_select <= 1'b0;
      decel_stall_prevent_select <= stall_pkg::DEC_OFF;
      running_stall_prevent_select <= 1'b0;
      running_overvolt_prevent_select <= 1'b0;
      use_two <= 1'b0;
      accel_current_limit_level <= stall_pkg::PCT_RESET;
      decel_current_limit_level <= stall_pkg::PCT_RESET;
      running_current_limit_level <= stall_pkg::PCT_RESET;
      running_overvolt_prevent_level <= LVL_RST;
      decel_overvolt_restraint_gain <= stall_pkg::GAIN_RESET;
      accel_time_one <= stall_pkg::STEP_RESET;
      decel_time_one <= stall_pkg::STEP_RESET;
      accel_time_two <= stall_pkg::STEP_RESET;
      decel_time_two <= stall_pkg::STEP_RESET;
    end
    else if (wr)
    begin
      case (address_i)
        stall_pkg::ADDR_SEL:
        begin
          accel_stall_prevent_select <= writedata_i[0];
          // Reserved selector code falls back to the fully enabled mode
          decel_stall_prevent_select <= (writedata_i[2:1] == 2'h3) ? stall_pkg::DEC_ALL :
                                        stall_pkg::decel_sel_e'(writedata_i[2:1]);
          running_stall_prevent_select <= writedata_i[3];
          running_overvolt_prevent_select <= writedata_i[4];
          use_two <= writedata_i[5];
        end
        stall_pkg::ADDR_ACC_LIM: accel_current_limit_level <= clip_pct(writedata_i);
        stall_pkg::ADDR_DEC_LIM: decel_current_limit_level <= clip_pct(writedata_i);
        stall_pkg::ADDR_RUN_LIM: running_current_limit_level <= clip_pct(writedata_i);
        stall_pkg::ADDR_OV_LEVEL:
          running_overvolt_prevent_level <= (writedata_i[12:0] < LVL_MIN) ? LVL_MIN :
                                            (writedata_i[12:0] > LVL_MAX) ? LVL_MAX :
                                            writedata_i[12:0];
        stall_pkg::ADDR_GAIN:
          decel_overvolt_restraint_gain <= (writedata_i[4:0] > stall_pkg::GAIN_MAX) ?
                                           stall_pkg::GAIN_MAX : writedata_i[4:0];
        stall_pkg::ADDR_ACC_ONE: accel_time_one <= writedata_i[15:0];
        stall_pkg::ADDR_DEC_ONE: decel_time_one <= writedata_i[15:0];
        stall_pkg::ADDR_ACC_TWO: accel_time_two <= writedata_i[15:0];
        stall_pkg::ADDR_DEC_TWO: decel_time_two <= writedata_i[15:0];
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      readdata_o <= 32'h0;
    else if (rd)
    begin
      case (address_i)
        stall_pkg::ADDR_SEL:
          readdata_o <= {26'h0, use_two, running_overvolt_prevent_select,
                         running_stall_prevent_select, decel_stall_prevent_select,
                         accel_stall_prevent_select};
        stall_pkg::ADDR_ACC_LIM: readdata_o <= {24'h0, accel_current_limit_level};
        stall_pkg::ADDR_DEC_LIM: readdata_o <= {24'h0, decel_current_limit_level};
        stall_pkg::ADDR_RUN_LIM: readdata_o <= {24'h0, running_current_limit_level};
        stall_pkg::ADDR_OV_LEVEL: readdata_o <= {19'h0, running_overvolt_prevent_level};
        stall_pkg::ADDR_GAIN: readdata_o <= {27'h0, decel_overvolt_restraint_gain};
        stall_pkg::ADDR_ACC_ONE: readdata_o <= {16'h0, accel_time_one};
        stall_pkg::ADDR_DEC_ONE: readdata_o <= {16'h0, decel_time_one};
        stall_pkg::ADDR_ACC_TWO: readdata_o <= {16'h0, accel_time_two};
        stall_pkg::ADDR_DEC_TWO: readdata_o <= {16'h0, decel_time_two};
        stall_pkg::ADDR_STATUS:
          readdata_o <= {16'h0, freq_o[11:0], stalled_o, overcurrent_fault_o,
                         overload_fault_o, overvoltage_fault_o};
        default: readdata_o <= 32'h0;
      endcase
    end
  end

  logic [15:0] acc_step;
  logic [15:0] dec_step;
  logic [15:0] dec_slow;
  logic stopping;
  logic dec_guard;
  logic bus_high;
  logic bus_trip;
  logic ov_raise;
  assign acc_step = use_two ? accel_time_two : accel_time_one;
  assign dec_step = use_two ? decel_time_two : decel_time_one;
  // Higher gain stretches deceleration less, trading bus headroom for stop time
  // Product kept at full width so long steps with a high gain do not wrap
  assign dec_slow = 16'((21'(dec_step) * 21'(decel_overvolt_restraint_gain)) / 21'h000019);
  assign stopping = !run_i;
  assign bus_trip = bus_volt_i > OV_TRIP;
  assign bus_high = bus_volt_i > running_overvolt_prevent_level;
  assign dec_guard = (decel_stall_prevent_select == stall_pkg::DEC_ALL) ||
                     (decel_stall_prevent_select == stall_pkg::DEC_CHANGE_ONLY &&
                      !stopping);
  assign ov_raise = running_overvolt_prevent_select && run_i && bus_high;
  assign set_freq = run_i ? target_freq_i : 16'h0;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dwell_cnt <= 32'h0;
      run_limiting <= 1'b0;
    end
    else if (update_i)
    begin
      if (state == stall_pkg::RAMP_STEADY && running_stall_prevent_select && lim.on_run &&
          lim.over_run)
      begin
        if (dwell_cnt >= DWELL)
          run_limiting <= 1'b1;
        else
          dwell_cnt <= dwell_cnt + 32'h1;
      end
      else if (!lim.over_run || !run_i)
      begin
        dwell_cnt <= 32'h0;
        run_limiting <= 1'b0;
      end
    end
  end

  logic [15:0] next_freq;
  stall_pkg::ramp_state_e next_state;
  always_comb
  begin
    next_freq = freq_o;
    next_state = state;
    if (run_limiting)
    begin
      next_state = stall_pkg::RAMP_STALLED;
      next_freq = (freq_o > dec_step) ? freq_o - dec_step : 16'h0;
    end
    else if (ov_raise)
    begin
      next_state = stall_pkg::RAMP_ACCEL;
      next_freq = (16'hffff - freq_o > acc_step) ? freq_o + acc_step : 16'hffff;
    end
    else if (freq_o < set_freq)
    begin
      next_state = stall_pkg::RAMP_ACCEL;
      if (accel_stall_prevent_select && lim.on_acc && lim.over_acc)
        next_freq = freq_o;
      else
        next_freq = (set_freq - freq_o > acc_step) ? freq_o + acc_step : set_freq;
    end
    else if (freq_o > set_freq)
    begin
      next_state = stall_pkg::RAMP_DECEL;
      if (dec_guard && ((lim.on_dec && lim.over_dec) || bus_high))
        next_freq = freq_o;
      else if (dec_guard && bus_volt_i > (running_overvolt_prevent_level >> 1))
        next_freq = (freq_o - set_freq > dec_slow) ? freq_o - dec_slow : set_freq;
      else
        next_freq = (freq_o - set_freq > dec_step) ? freq_o - dec_step : set_freq;
    end
    else
      next_state = run_i ? stall_pkg::RAMP_STEADY : stall_pkg::RAMP_IDLE;
  end

  logic any_fault;
  assign any_fault = overvoltage_fault_o || overload_fault_o || overcurrent_fault_o;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      freq_o <= 16'h0;
      state <= stall_pkg::RAMP_IDLE;
      stalled_o <= 1'b0;
    end
    else if (any_fault)
    begin
      freq_o <= 16'h0;
      state <= stall_pkg::RAMP_IDLE;
      stalled_o <= 1'b0;
    end
    else if (update_i)
    begin
      freq_o <= next_freq;
      state <= next_state;
      case (next_state)
        stall_pkg::RAMP_STALLED: stalled_o <= 1'b1;
        stall_pkg::RAMP_ACCEL: stalled_o <= next_freq == freq_o && !ov_raise;
        stall_pkg::RAMP_DECEL: stalled_o <= next_freq == freq_o;
        default: stalled_o <= 1'b0;
      endcase
    end
  end

  // Faults are sticky; a new trip in the clear cycle wins over the clear
  logic fault_clr;
  assign fault_clr = wr && address_i == stall_pkg::ADDR_FAULT_CLR;
  logic trip_ov;
  logic trip_run;
  assign trip_ov = update_i && bus_trip && decel_stall_prevent_select == stall_pkg::DEC_OFF &&
                   state == stall_pkg::RAMP_DECEL;
  assign trip_run = update_i && !running_stall_prevent_select && lim.on_run && lim.over_run &&
                    state == stall_pkg::RAMP_STEADY;
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      overvoltage_fault_o <= 1'b0;
      overload_fault_o <= 1'b0;
      overcurrent_fault_o <= 1'b0;
    end
    else
    begin
      overvoltage_fault_o <= trip_ov || (overvoltage_fault_o && !(fault_clr && writedata_i[0]));
      overload_fault_o <= trip_run || (overload_fault_o && !(fault_clr && writedata_i[1]));
      overcurrent_fault_o <= (trip_run && current_i > 16'(2 * RATED)) ||
                             (overcurrent_fault_o && !(fault_clr && writedata_i[2]));
    end
  end
endmodule : stall_prevention_controller

// ---- sim/stall_prevention_controller_sva.sv ----
// Port checker for the stall prevention controller
`timescale 1ns/1ps
module stall_prevention_controller_sva (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  input wire logic run_i,
  input wire logic [15:0] target_freq_i,
  input wire logic [15:0] current_i,
  input wire logic [12:0] bus_volt_i,
  input wire logic update_i,
  input wire logic [15:0] freq_o,
  input wire logic overvoltage_fault_o,
  input wire logic overload_fault_o,
  input wire logic overcurrent_fault_o,
  input wire logic stalled_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  logic req;
  logic acc;
  logic flt;
  logic clr;
  assign req = read_i || write_i;
  assign acc = req && !waitrequest_o;
  assign flt = overvoltage_fault_o || overload_fault_o || overcurrent_fault_o;
  assign clr = acc && write_i && address_i == stall_pkg::ADDR_FAULT_CLR;
  a_bus_one_wait: assert property (req && waitrequest_o |=> !waitrequest_o)
    else $error("waitrequest held past one wait state");
  a_bus_recover: assert property (acc |=> waitrequest_o)
    else $error("waitrequest low two cycles running");
  // A fault may move the output without an update, only towards zero
  a_freq_on_update: assert property (!update_i |=> $stable(freq_o) || flt)
    else $error("frequency moved without an update");
  a_fault_zero_freq: assert property (flt && $past(flt) |-> freq_o == 16'h0)
    else $error("frequency not zero under a fault");
  a_ov_fault_sticky: assert property (overvoltage_fault_o && !clr |=> overvoltage_fault_o)
    else $error("overvoltage fault dropped without clear");
  a_ol_fault_sticky: assert property (overload_fault_o && !clr |=> overload_fault_o)
    else $error("overload fault dropped without clear");
  a_stop_never_rises: assert property (!run_i && update_i |=> freq_o <= $past(freq_o))
    else $error("frequency rose while stopping");
  a_acc_limit_range: assert property (
    acc && read_i && address_i == stall_pkg::ADDR_ACC_LIM
    |-> readdata_o[7:0] inside {[stall_pkg::PCT_MIN:stall_pkg::PCT_MAX]})
    else $error("acceleration limit out of range");
  a_dec_limit_range: assert property (
    acc && read_i && address_i == stall_pkg::ADDR_DEC_LIM
    |-> readdata_o[7:0] inside {[stall_pkg::PCT_MIN:stall_pkg::PCT_MAX]})
    else $error("deceleration limit out of range");
  a_gain_range: assert property (
    acc && read_i && address_i == stall_pkg::ADDR_GAIN
    |-> readdata_o[4:0] <= stall_pkg::GAIN_MAX)
    else $error("restraint gain out of range");
  c_read: cover property (acc && read_i);
  c_stall: cover property ($rose(stalled_o));
  c_ov_trip: cover property ($rose(overvoltage_fault_o));
endmodule : stall_prevention_controller_sva
bind stall_prevention_controller stall_prevention_controller_sva i_sva (
  .clock_i(clock_i), .resetn_i(resetn_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .run_i(run_i), .target_freq_i(target_freq_i),
  .current_i(current_i), .bus_volt_i(bus_volt_i), .update_i(update_i), .freq_o(freq_o),
  .overvoltage_fault_o(overvoltage_fault_o), .overload_fault_o(overload_fault_o),
  .overcurrent_fault_o(overcurrent_fault_o), .stalled_o(stalled_o));

// ---- sim/motor_model.sv ----
// Motor load and bus sensor stand-in on the drive's output side
`timescale 1ns/1ps
module motor_model (
  input wire logic clock_i,
  input wire logic [15:0] load_i,
  input wire logic [12:0] bus_i,
  output logic [15:0] current_o = 16'h0000,
  output logic [12:0] bus_volt_o = 13'h0000
);
  // Sensor latency of one cycle, so no change is seen in the cycle it is made
  always @(posedge clock_i)
  begin
    current_o <= load_i;
    bus_volt_o <= bus_i;
  end
endmodule : motor_model

// ---- sim/tb_stall_prevention_controller.sv ----
// Self-checking bench for the stall prevention controller
`timescale 1ns/1ps
module tb_stall_prevention_controller;
  localparam logic [12:0] BN = 13'h05dc;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] address_i = 4'h0;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic run_i = 1'b0;
  logic [15:0] target_freq_i = 16'h0;
  logic [15:0] current_i;
  logic [12:0] bus_volt_i;
  logic update_i = 1'b0;
  logic [15:0] freq_o;
  logic ovf, olf, ocf, stalled_o;
  logic [15:0] load = 16'h0;
  logic [12:0] bus = BN;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int checks_done = 0;
  always #12.5 clock_i = ~clock_i;
  stall_prevention_controller #(.RATED(1000), .DWELL_CYCLES(8), .CLASS_400(1'b0)) i_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .run_i(run_i), .target_freq_i(target_freq_i),
    .current_i(current_i), .bus_volt_i(bus_volt_i), .update_i(update_i), .freq_o(freq_o),
    .overvoltage_fault_o(ovf), .overload_fault_o(olf), .overcurrent_fault_o(ocf),
    .stalled_o(stalled_o));
  motor_model i_motor (.clock_i(clock_i), .load_i(load), .bus_i(bus),
    .current_o(current_i), .bus_volt_o(bus_volt_i));
  task automatic results;
    $display("Errors %0d in %0d checks", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Read data stand from the end of the wait state on, so they are taken at the accepting edge
  always @(posedge clock_i)
    if (read_i === 1'b1 && waitrequest_o === 1'b0)
      cmp(readdata_o, exp_q.pop_front());
  task automatic bus_cycle(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    read_i <= ~w;
    write_i <= w;
    address_i <= a;
    writedata_i <= d;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (waitrequest_o !== 1'b0 && n < 40);
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge clock_i);
    if (n >= 40)
    begin
      num_errors++;
      results();
    end
  endtask : bus_cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus_cycle(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus_cycle(1'b0, a, 32'h0);
  endtask : rd
  task automatic clip(input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
    wr(a, d);
    rd(a, e);
  endtask : clip
  task automatic upd(input int n);
    repeat (n)
    begin
      update_i <= 1'b1;
      @(posedge clock_i);
      update_i <= 1'b0;
      repeat (2) @(posedge clock_i);
    end
  endtask : upd
  // Load reaches the limit flags two cycles late, bus its comparisons one; four leaves margin
  task automatic env(input logic [15:0] l, input logic [12:0] b);
    load <= l;
    bus <= b;
    repeat (4) @(posedge clock_i);
  endtask : env
  task automatic go(input logic r, input logic [15:0] t);
    run_i <= r;
    target_freq_i <= t;
    @(posedge clock_i);
  endtask : go
  function automatic logic [31:0] rst_val(input int i);
    case (i)
      1, 2, 3: return 32'(stall_pkg::PCT_RESET);
      4: return 32'(stall_pkg::BUS200_RESET);
      5: return 32'(stall_pkg::GAIN_RESET);
      6, 7, 8, 9: return 32'(stall_pkg::STEP_RESET);
      default: return 32'h0;
    endcase
  endfunction : rst_val
  initial
  begin
    logic [31:0] r;
    void'($urandom(32'h1419357a));
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    for (int i = 0; i <= 12; i++)
      if (i != 11)
        rd(4'(i), rst_val(i));
    clip(4'h1, 32'h14, 32'h32);
    clip(4'h2, 32'hff, 32'hc8);
    clip(4'h5, 32'h1f, 32'h19);
    clip(4'h4, 32'h3e8, 32'hdac);
    clip(4'h4, 32'h1fff, 32'hf3c);
    clip(4'hd, 32'h55, 32'h0);
    r = 32'h32 + ($urandom % 151);
    clip(4'h1, r, r);
    r = $urandom % 26;
    clip(4'h5, r, r);
    wr(4'h4, 32'hed8);
    wr(4'h5, 32'ha);
    wr(4'h1, 32'h64);
    env(16'd1400, BN);
    go(1'b1, 16'd64);
    for (int k = 1; k <= 4; k++)
    begin
      upd(1);
      cmp(freq_o, 16 * k);
    end
    env(16'd0, BN);
    go(1'b0, 16'd64);
    upd(4);
    cmp(freq_o, 32'h0);
    wr(4'h0, 32'h1);
    env(16'd1400, BN);
    go(1'b1, 16'd64);
    upd(3);
    cmp(freq_o, 32'h0);
    cmp(stalled_o, 32'h1);
    env(16'd500, BN);
    upd(4);
    cmp(freq_o, 32'd64);
    env(16'd0, BN);
    go(1'b0, 16'd64);
    upd(4);
    wr(4'h1, 32'hc8);
    env(16'd2100, BN);
    go(1'b1, 16'd32);
    upd(2);
    cmp(freq_o, 32'd32);
    env(16'd0, BN);
    wr(4'h0, 32'h2);
    wr(4'h2, 32'h64);
    go(1'b1, 16'd64);
    upd(2);
    env(16'd1400, BN);
    go(1'b0, 16'd64);
    upd(2);
    cmp(freq_o, 32'd64);
    cmp(stalled_o, 32'h1);
    env(16'd0, BN);
    upd(4);
    cmp(freq_o, 32'h0);
    go(1'b1, 16'd64);
    upd(4);
    env(16'd0, 13'h09c4);
    go(1'b0, 16'd64);
    upd(2);
    cmp(freq_o, 32'h34);
    wr(4'h0, 32'h4);
    go(1'b1, 16'd64);
    upd(4);
    env(16'd1400, BN);
    go(1'b0, 16'd64);
    upd(1);
    cmp(freq_o, 32'd48);
    go(1'b1, 16'd16);
    upd(1);
    cmp(freq_o, 32'd48);
    env(16'd0, BN);
    upd(2);
    cmp(freq_o, 32'd16);
    wr(4'h0, 32'h0);
    go(1'b1, 16'd64);
    upd(3);
    go(1'b0, 16'd64);
    env(16'd0, 13'h1100);
    upd(2);
    cmp(ovf, 32'h1);
    cmp(freq_o, 32'h0);
    env(16'd0, BN);
    wr(4'hb, 32'h7);
    cmp(ovf, 32'h0);
    wr(4'h0, 32'h8);
    wr(4'h3, 32'h64);
    go(1'b1, 16'd64);
    upd(4);
    env(16'd1400, BN);
    upd(6);
    cmp(freq_o, 32'd64);
    upd(10);
    cmp(freq_o < 16'd64, 32'h1);
    cmp(stalled_o, 32'h1);
    env(16'd0, BN);
    upd(6);
    cmp(freq_o, 32'd64);
    wr(4'h3, 32'hc8);
    env(16'd2100, BN);
    upd(12);
    cmp(freq_o, 32'd64);
    rd(4'ha, 32'h400);
    wr(4'h0, 32'h0);
    wr(4'h3, 32'h64);
    env(16'd1400, BN);
    upd(12);
    cmp(olf, 32'h1);
    cmp(freq_o, 32'h0);
    env(16'd0, BN);
    wr(4'hb, 32'h7);
    cmp(olf, 32'h0);
    upd(4);
    env(16'd2100, BN);
    upd(12);
    cmp(ocf, 32'h1);
    env(16'd0, BN);
    wr(4'hb, 32'h7);
    wr(4'h0, 32'h10);
    upd(4);
    env(16'd0, 13'h0f3c);
    upd(2);
    cmp(freq_o > 16'd64, 32'h1);
    results();
  end
endmodule : tb_stall_prevention_controller
